// file: dlel_defs.svh
/*
  Constants of the drive log directory and extended error log block:
  register byte addresses, field positions, reset values, fixed log bytes
  and timing figures.
  Assumes inclusion by bare name from the block's source files.
*/
`ifndef DLEL_DEFS_SVH
`define DLEL_DEFS_SVH

// ==========================================================================
// Register byte addresses
`define DLEL_REG_CTRL 8'h00
`define DLEL_REG_STATUS 8'h04

// ==========================================================================
// Control fields and reset value
`define DLEL_CTRL_NCQ 0
`define DLEL_CTRL_PHY 1
`define DLEL_CTRL_QMGMT 2
`define DLEL_CTRL_REBUILD 3
`define DLEL_CTRL_ERRLOG 4
`define DLEL_CTRL_RESET 5'h10

// ==========================================================================
// Status fields
`define DLEL_STAT_INDEX_LSB 0
`define DLEL_STAT_COUNT_LSB 16

// ==========================================================================
// Log addresses and sector counts
`define DLEL_LOG_DIR 8'h00
`define DLEL_LOG_ERR 8'h03
`define DLEL_LOG_HOST_LO 8'h80
`define DLEL_LOG_HOST_HI 8'h9F
`define DLEL_LOG_NCQ 8'h10
`define DLEL_LOG_PHY 8'h11
`define DLEL_LOG_QMGMT 8'h12
`define DLEL_LOG_REBUILD 8'h15
`define DLEL_HOST_LOG_SECTORS 8'h10
`define DLEL_ERR_LOG_SECTORS 16'h0001
`define DLEL_DIR_VERSION 16'h0001

// ==========================================================================
// Error log sector layout
`define DLEL_ERR_VERSION 8'h01
`define DLEL_ERR_OFS_INDEX 9'h002
`define DLEL_ERR_OFS_REC0 9'h004
`define DLEL_ERR_OFS_REC1 9'h080
`define DLEL_ERR_OFS_REC2 9'h0FC
`define DLEL_ERR_OFS_REC3 9'h178
`define DLEL_ERR_OFS_COUNT 9'h1F4
`define DLEL_ERR_OFS_CSUM 9'h1FF
`define DLEL_REC_BYTES 124
`define DLEL_CMD_SNAP_BYTES 18
`define DLEL_ERR_SNAP_BYTES 34
`define DLEL_HIST_DEPTH 5

// ==========================================================================
// Timing
`define DLEL_CLK_PERIOD_NS 20
`define DLEL_MS_NS 1000000

`endif

// file: dlel_pkg.sv
/*
  Types of the drive log directory and extended error log block.
  Assumes nothing of its surroundings.
*/
package dlel_pkg;

  // Log read sequencer
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_SCAN,
    RD_DONE
  } dlel_rd_state_type;

  // Power state codes kept in the error snapshot
  typedef logic [3:0] dlel_power_type;

endpackage : dlel_pkg

// file: dlel_log_core.sv
/*
  Drive log directory and extended comprehensive error log sector server.
  Assumes: one clock, synchronous inputs, an AXI4-Lite master, a taskfile
  write/command-issue feed and an error event feed from drive firmware.
*/
// Our own choices: register access over AXI4-Lite and the register offsets.
// Function
// - Directory begins with version word 0001h; 0000h would mean no directory.
// - Directory holds 16-bit sector count per log, low then high, at twice address.
// - Host logs 80h through 9Fh report sixteen sectors each.
// - Byte 020h shows queued command support, byte 021h is zero.
// - Byte 022h shows phy event counters, byte 023h is zero.
// - Byte 024h shows queue management support, byte 025h is zero.
// - Byte 02Ah shows rebuild assist log; 02Bh zero; reserved bytes read zero.
// - Errors from malformed host commands are never recorded.
// - Error sector: version, index, four 124-byte records, error count, checksum.
// - Error log version byte is 01h.
// - Index names newest record, zero when empty, only values 0 through 4.
// - Four records are circular; unwritten records read as zeros.
// - Record holds five 18-byte command snapshots then a 34-byte error snapshot.
// - Command snapshot field order with opcode at 0Ch and millisecond stamp at 0Eh.
// - Snapshot low byte is latest written value, high byte the prior one.
// - Error snapshot: error, taskfile pairs, status, vendor bytes, state, hours.
// - Error snapshot low byte read with bit 7 clear, high byte with it set.
// - State code low nibble: unknown, sleep, standby, active/idle, offline.
// - State code is the power state when the failing command was issued.
// - Device error count accumulates every device error reported.
// - Device error count excludes malformed host command errors.
// - Device error count saturates at its maximum and never wraps.
// - Log read aborts for unsupported or disabled log or invalid fields.
`timescale 1ns/100ps
`include "dlel_defs.svh"

module dlel_log_core #(
  parameter int CYCLES_PER_MS = (`DLEL_MS_NS + `DLEL_CLK_PERIOD_NS - 1) / `DLEL_CLK_PERIOD_NS
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic tf_wr_in,
  input wire logic [2:0] tf_sel_in,
  input wire logic [7:0] tf_data_in,
  input wire logic cmd_issue_in,
  input wire logic [7:0] cmd_op_in,
  input wire dlel_pkg::dlel_power_type power_state_in,
  input wire logic err_valid_in,
  input wire logic err_host_fault_in,
  input wire logic [7:0] err_code_in,
  input wire logic [7:0] err_status_in,
  input wire logic [71:0] err_tf_in,
  input wire logic [151:0] err_vendor_in,
  input wire logic [15:0] life_hours_in,
  input wire logic lr_req_in,
  input wire logic [7:0] lr_log_in,
  input wire logic [15:0] lr_page_in,
  input wire logic [8:0] lr_byte_in,
  output logic lr_busy_out,
  output logic lr_done_out,
  output logic lr_abort_out,
  output logic [7:0] lr_data_out
);
  import dlel_pkg::*;

  if (CYCLES_PER_MS < 2) begin : g_bad_ms
    $error("CYCLES_PER_MS must be at least 2");
  end

  // ========================================================================
  // Register file over AXI4-Lite
  logic [4:0] ctrl;
  logic [2:0] err_index;
  logic [15:0] err_count;
  logic wr_take;
  logic rd_take;

  assign wr_take = s_axi_awvalid_in && s_axi_wvalid_in && !s_axi_awready_out && !s_axi_bvalid_out;
  assign rd_take = s_axi_arvalid_in && !s_axi_arready_out && !s_axi_rvalid_out;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= 2'h0;
      ctrl <= `DLEL_CTRL_RESET;
    end else begin
      s_axi_awready_out <= wr_take;
      s_axi_wready_out <= wr_take;
      if (wr_take) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= 2'h0;
        if (s_axi_awaddr_in[7:2] == `DLEL_REG_CTRL >> 2) begin
          if (s_axi_wstrb_in[0]) begin
            ctrl <= s_axi_wdata_in[4:0];
          end
        end else if (s_axi_awaddr_in[7:2] != `DLEL_REG_STATUS >> 2) begin
          s_axi_bresp_out <= 2'h2;
        end
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rresp_out <= 2'h0;
      s_axi_rdata_out <= 32'h0000_0000;
    end else begin
      s_axi_arready_out <= rd_take;
      if (rd_take) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= 2'h0;
        s_axi_rdata_out <= 32'h0000_0000;
        if (s_axi_araddr_in[7:2] == `DLEL_REG_CTRL >> 2) begin
          s_axi_rdata_out <= {27'h000_0000, ctrl};
        end else if (s_axi_araddr_in[7:2] == `DLEL_REG_STATUS >> 2) begin
          s_axi_rdata_out <= {err_count, 13'h0000, err_index};
        end else begin
          s_axi_rresp_out <= 2'h2;
        end
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Taskfile shadow, millisecond clock and command history
  logic [7:0] tf_cur [7];
  logic [7:0] tf_prev [7];
  logic [31:0] ms_time;
  logic [31:0] ms_div;
  logic [143:0] hist [`DLEL_HIST_DEPTH];
  dlel_power_type issue_state;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < 7; i++) begin
        tf_cur[i] <= 8'h00;
        tf_prev[i] <= 8'h00;
      end
    end else if (tf_wr_in && tf_sel_in != 3'h7) begin
      tf_prev[tf_sel_in] <= tf_cur[tf_sel_in];
      tf_cur[tf_sel_in] <= tf_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      ms_div <= 32'h0000_0000;
      ms_time <= 32'h0000_0000;
    end else if (ms_div == 32'(CYCLES_PER_MS - 1)) begin
      ms_div <= 32'h0000_0000;
      ms_time <= ms_time + 32'h0000_0001;
    end else begin
      ms_div <= ms_div + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < `DLEL_HIST_DEPTH; i++) begin
        hist[i] <= 144'h0;
      end
      issue_state <= 4'h0;
    end else if (cmd_issue_in) begin
      for (int i = 0; i < `DLEL_HIST_DEPTH - 1; i++) begin
        hist[i] <= hist[i + 1];
      end
      // Byte 0 sits in the low bits
      hist[`DLEL_HIST_DEPTH - 1] <= {ms_time, 8'h00, cmd_op_in, tf_cur[6],
        tf_prev[5], tf_cur[5], tf_prev[4], tf_cur[4], tf_prev[3], tf_cur[3],
        tf_prev[2], tf_cur[2], tf_prev[1], tf_cur[1], tf_cur[0]};
      issue_state <= power_state_in;
    end
  end

  // ========================================================================
  // Error records, index and lifetime count
  logic [7:0] rec [4][`DLEL_REC_BYTES];
  logic [991:0] rec_new;
  logic [1:0] wr_slot;
  logic err_log_ok;

  assign err_log_ok = err_valid_in && !err_host_fault_in;
  assign rec_new = {life_hours_in, 4'h0, issue_state, err_vendor_in, err_status_in,
    err_tf_in, err_code_in, 8'h00,
    hist[4], hist[3], hist[2], hist[1], hist[0]};

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      for (int r = 0; r < 4; r++) begin
        for (int k = 0; k < `DLEL_REC_BYTES; k++) begin
          rec[r][k] <= 8'h00;
        end
      end
    end else if (err_log_ok) begin
      for (int k = 0; k < `DLEL_REC_BYTES; k++) begin
        rec[wr_slot][k] <= rec_new[k * 8 +: 8];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      wr_slot <= 2'h0;
      err_index <= 3'h0;
    end else if (err_log_ok) begin
      wr_slot <= wr_slot + 2'h1;
      err_index <= {1'b0, wr_slot} + 3'h1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      err_count <= 16'h0000;
    end else if (err_log_ok && err_count != 16'hFFFF) begin
      err_count <= err_count + 16'h0001;
    end
  end

  // ========================================================================
  // Sector byte muxes
  logic [8:0] mux_addr;
  logic [8:0] scan_addr;
  logic [7:0] err_byte;
  logic [7:0] dir_byte;
  logic [7:0] dir_log;
  logic [1:0] rsel;
  logic [6:0] roff;
  dlel_rd_state_type rd_state;

  assign mux_addr = (rd_state == RD_SCAN) ? scan_addr : lr_byte_in;
  assign dir_log = mux_addr[8:1];

  always_comb begin
    dir_byte = 8'h00;
    if (mux_addr == 9'h000) begin
      dir_byte = 8'(`DLEL_DIR_VERSION);
    end else if (mux_addr == 9'h001) begin
      dir_byte = 8'(`DLEL_DIR_VERSION >> 8);
    end else if (dir_log == `DLEL_LOG_ERR) begin
      dir_byte = mux_addr[0] ? 8'(`DLEL_ERR_LOG_SECTORS >> 8) : 8'(`DLEL_ERR_LOG_SECTORS);
    end else if (dir_log >= `DLEL_LOG_HOST_LO && dir_log <= `DLEL_LOG_HOST_HI) begin
      dir_byte = mux_addr[0] ? 8'h00 : `DLEL_HOST_LOG_SECTORS;
    end else if (!mux_addr[0]) begin
      case (dir_log)
        `DLEL_LOG_NCQ: dir_byte = {7'h00, ctrl[`DLEL_CTRL_NCQ]};
        `DLEL_LOG_PHY: dir_byte = {7'h00, ctrl[`DLEL_CTRL_PHY]};
        `DLEL_LOG_QMGMT: dir_byte = {7'h00, ctrl[`DLEL_CTRL_QMGMT]};
        `DLEL_LOG_REBUILD: dir_byte = {7'h00, ctrl[`DLEL_CTRL_REBUILD]};
        default: dir_byte = 8'h00;
      endcase
    end
  end

  always_comb begin
    rsel = 2'h0;
    roff = 7'h00;
    if (mux_addr < `DLEL_ERR_OFS_REC1) begin
      roff = 7'(mux_addr - `DLEL_ERR_OFS_REC0);
    end else if (mux_addr < `DLEL_ERR_OFS_REC2) begin
      rsel = 2'h1;
      roff = 7'(mux_addr - `DLEL_ERR_OFS_REC1);
    end else if (mux_addr < `DLEL_ERR_OFS_REC3) begin
      rsel = 2'h2;
      roff = 7'(mux_addr - `DLEL_ERR_OFS_REC2);
    end else begin
      rsel = 2'h3;
      roff = 7'(mux_addr - `DLEL_ERR_OFS_REC3);
    end
    err_byte = 8'h00;
    if (mux_addr == 9'h000) begin
      err_byte = `DLEL_ERR_VERSION;
    end else if (mux_addr == `DLEL_ERR_OFS_INDEX) begin
      err_byte = {5'h00, err_index};
    end else if (mux_addr >= `DLEL_ERR_OFS_REC0 && mux_addr < `DLEL_ERR_OFS_COUNT) begin
      err_byte = rec[rsel][roff];
    end else if (mux_addr == `DLEL_ERR_OFS_COUNT) begin
      err_byte = err_count[7:0];
    end else if (mux_addr == `DLEL_ERR_OFS_COUNT + 9'h001) begin
      err_byte = err_count[15:8];
    end
  end

  // ========================================================================
  // Log read sequencer
  logic [7:0] csum;
  logic bad_req;
  logic csum_req;

  always_comb begin
    bad_req = 1'b1;
    if (lr_log_in == `DLEL_LOG_DIR) begin
      bad_req = lr_page_in != 16'h0000;
    end else if (lr_log_in == `DLEL_LOG_ERR) begin
      bad_req = !ctrl[`DLEL_CTRL_ERRLOG] || lr_page_in >= `DLEL_ERR_LOG_SECTORS;
    end
  end

  assign csum_req = lr_log_in == `DLEL_LOG_ERR && lr_byte_in == `DLEL_ERR_OFS_CSUM;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      rd_state <= RD_IDLE;
      scan_addr <= 9'h000;
      csum <= 8'h00;
      lr_busy_out <= 1'b0;
      lr_done_out <= 1'b0;
      lr_abort_out <= 1'b0;
      lr_data_out <= 8'h00;
    end else begin
      lr_done_out <= 1'b0;
      case (rd_state)
        RD_IDLE: begin
          if (lr_req_in) begin
            lr_abort_out <= bad_req;
            lr_data_out <= 8'h00;
            if (bad_req) begin
              lr_done_out <= 1'b1;
            end else if (csum_req) begin
              rd_state <= RD_SCAN;
              lr_busy_out <= 1'b1;
              scan_addr <= 9'h000;
              csum <= 8'h00;
            end else begin
              lr_done_out <= 1'b1;
              lr_data_out <= (lr_log_in == `DLEL_LOG_DIR) ? dir_byte : err_byte;
            end
          end
        end
        RD_SCAN: begin
          csum <= csum + err_byte;
          scan_addr <= scan_addr + 9'h001;
          if (scan_addr == `DLEL_ERR_OFS_CSUM - 9'h001) begin
            rd_state <= RD_DONE;
          end
        end
        RD_DONE: begin
          lr_data_out <= 8'h00 - csum;
          lr_done_out <= 1'b1;
          lr_busy_out <= 1'b0;
          rd_state <= RD_IDLE;
        end
        default: rd_state <= RD_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Checks
  sequence s_csum_start;
    lr_req_in && !lr_busy_out && !bad_req && csum_req;
  endsequence

  sequence s_csum_answer;
    !lr_done_out [*8] ##[500:510] lr_done_out;
  endsequence

  a_csum_scan_time: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    s_csum_start |=> s_csum_answer) else $error("checksum answer not within scan time");

  a_index_range: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    err_index <= 3'h4) else $error("error index out of range");

  a_index_wraps: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    err_log_ok && err_index == 3'h4 |=> err_index == 3'h1) else $error("index did not wrap");

  a_fault_ignored: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    err_valid_in && err_host_fault_in |=> $stable(err_count) && $stable(err_index))
    else $error("host fault changed the error log");

  a_count_saturate: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    err_count == 16'hFFFF |=> err_count == 16'hFFFF) else $error("error count wrapped");

  a_count_steps: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    err_log_ok && err_count != 16'hFFFF |=> err_count == $past(err_count) + 16'h0001)
    else $error("error count did not step");

  a_bad_log_abort: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    lr_req_in && !lr_busy_out && lr_log_in != `DLEL_LOG_DIR && lr_log_in != `DLEL_LOG_ERR
    |=> lr_done_out && lr_abort_out)
    else $error("read of unserved log not aborted");

  a_err_version: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    lr_req_in && !lr_busy_out && !bad_req && lr_log_in == `DLEL_LOG_ERR && lr_byte_in == 9'h000
    |=> lr_done_out && lr_data_out == 8'h01) else $error("error log version wrong");

  a_host_log_size: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    lr_req_in && !lr_busy_out && lr_log_in == `DLEL_LOG_DIR && lr_page_in == 16'h0000
    && lr_byte_in[8] && !lr_byte_in[7] && !lr_byte_in[6] && !lr_byte_in[0]
    |=> lr_data_out == 8'h10) else $error("host log size not sixteen");

  a_axi_write_resp: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    wr_take |=> s_axi_bvalid_out && s_axi_awready_out && s_axi_wready_out)
    else $error("write response missing");

endmodule : dlel_log_core

// file: dlel_host_model.sv
/*
  Host side model: issues log byte reads and collects each answer.
  Assumes the block answers with a done pulse within 600 cycles.
*/
`timescale 1ns/100ps

module dlel_host_model (
  input wire logic clock_in,
  input wire logic lr_done_in,
  input wire logic lr_abort_in,
  input wire logic [7:0] lr_data_in,
  output logic lr_req_out,
  output logic [7:0] lr_log_out,
  output logic [15:0] lr_page_out,
  output logic [8:0] lr_byte_out
);
  // ==========================================================================
  // Byte read
  initial begin
    lr_req_out = 1'h0;
    lr_log_out = 8'hFF;
    lr_page_out = 16'hFFFF;
    lr_byte_out = 9'h1FF;
  end

  task automatic rd(input logic [7:0] lg, input logic [15:0] pg, input logic [8:0] by,
                    output logic [7:0] d, output logic ab);
    int n;
    n = 0;
    @(posedge clock_in);
    lr_req_out <= 1'h1;
    lr_log_out <= lg;
    lr_page_out <= pg;
    lr_byte_out <= by;
    @(posedge clock_in);
    // Released fields show the inverse so stale values cannot pass
    lr_req_out <= 1'h0;
    lr_log_out <= ~lg;
    lr_page_out <= ~pg;
    lr_byte_out <= ~by;
    while (lr_done_in !== 1'h1 && n < 600) begin
      @(posedge clock_in);
      n++;
    end
    // A missing answer reads as unknown so that every compare on it fails
    if (n >= 600) begin
      d = 8'hXX;
      ab = 1'hX;
    end else begin
      d = lr_data_in;
      ab = lr_abort_in;
    end
  endtask : rd
endmodule : dlel_host_model

// file: dlel_log_core_bench.sv
/*
  Self-checking bench of the log directory and error log block.
  Assumes the design files and the host model are compiled first.
*/
`timescale 1ns/100ps

module dlel_log_core_bench;
  import dlel_pkg::*;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, lr_req, lr_busy, lr_done, la;
  logic [1:0] bresp, rresp, r;
  logic tf_wr = 1'h0, cmd = 1'h0, err_v = 1'h0, err_hf = 1'h0;
  logic [2:0] tf_sel = 3'h0;
  logic [7:0] tf_data = 8'h00, cmd_op = 8'h00, err_code = 8'h00, lr_log, ld;
  dlel_power_type pwr = 4'h0;
  logic [15:0] lr_page;
  logic [8:0] lr_byte;
  logic lr_abort;
  logic [7:0] lr_data;
  int n_errors = 0, checked = 0, s;

  always #10 clk = ~clk;

  dlel_log_core #(.CYCLES_PER_MS(4)) u_dut (
    .clock_in(clk), .rst_b_in(rst_b),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .tf_wr_in(tf_wr), .tf_sel_in(tf_sel), .tf_data_in(tf_data),
    .cmd_issue_in(cmd), .cmd_op_in(cmd_op), .power_state_in(pwr),
    .err_valid_in(err_v), .err_host_fault_in(err_hf), .err_code_in(err_code),
    .err_status_in(8'h51), .err_tf_in(72'h5A), .err_vendor_in(152'h0),
    .life_hours_in(16'h0123), .lr_req_in(lr_req), .lr_log_in(lr_log),
    .lr_page_in(lr_page), .lr_byte_in(lr_byte), .lr_busy_out(lr_busy),
    .lr_done_out(lr_done), .lr_abort_out(lr_abort), .lr_data_out(lr_data));

  dlel_host_model u_host (
    .clock_in(clk), .lr_done_in(lr_done), .lr_abort_in(lr_abort),
    .lr_data_in(lr_data), .lr_req_out(lr_req), .lr_log_out(lr_log),
    .lr_page_out(lr_page), .lr_byte_out(lr_byte));

  // ==========================================================================
  // Shared tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task stop_test;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic ad, wd, bd;
    ad = 1'h0;
    wd = 1'h0;
    bd = 1'h0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    while (!bd) begin
      @(posedge clk);
      if (!ad && awready === 1'h1) begin ad = 1'h1; awv <= 1'h0; end
      if (!wd && wready === 1'h1) begin wd = 1'h1; wv <= 1'h0; end
      if (ad && wd && bvalid === 1'h1) begin bd = 1'h1; r = bresp; bready <= 1'h0; end
    end
  endtask : axi_wr

  task axi_rd(input logic [7:0] a);
    logic ad, dd;
    ad = 1'h0;
    dd = 1'h0;
    @(posedge clk);
    araddr <= a;
    arv <= 1'h1;
    rready <= 1'h1;
    while (!dd) begin
      @(posedge clk);
      if (!ad && arready === 1'h1) begin ad = 1'h1; arv <= 1'h0; end
      if (ad && rvalid === 1'h1) begin dd = 1'h1; d = rdata; r = rresp; rready <= 1'h0; end
    end
  endtask : axi_rd

  task lrb(input logic [7:0] lg, input logic [15:0] pg, input logic [8:0] by);
    u_host.rd(lg, pg, by, ld, la);
  endtask : lrb

  task lchk(input logic [8:0] by, input logic [7:0] exp);
    lrb(8'h03, 16'h0, by);
    chk(la, 1'h0);
    chk(ld, exp);
  endtask : lchk

  task pulse_ev(input int kind, input logic [7:0] v, input logic hf);
    @(posedge clk);
    if (kind == 0) begin tf_wr <= 1'h1; tf_sel <= 3'h1; tf_data <= v; end
    if (kind == 1) begin cmd <= 1'h1; cmd_op <= v; end
    if (kind == 2) begin err_v <= 1'h1; err_hf <= hf; err_code <= v; end
    @(posedge clk);
    tf_wr <= 1'h0;
    cmd <= 1'h0;
    err_v <= 1'h0;
  endtask : pulse_ev

  // ==========================================================================
  // Tests
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    axi_rd(8'h00);
    chk(d, 32'h10);
    axi_rd(8'h08);
    chk(d, 32'h0);
    chk(r, 2'h2);
    axi_wr(8'h08, 32'h0);
    chk(r, 2'h2);
    // Control byte lane off: the write must leave the control register alone
    wstrb <= 4'hE;
    axi_wr(8'h00, 32'h0);
    wstrb <= 4'hF;
    axi_rd(8'h00);
    chk(d, 32'h10);
    $display("test registers done");
    lrb(8'h00, 16'h0, 9'h000); chk(ld, 8'h01);
    lrb(8'h00, 16'h0, 9'h001); chk(ld, 8'h00);
    lrb(8'h00, 16'h0, 9'h006); chk(ld, 8'h01);
    lrb(8'h00, 16'h0, 9'h007); chk(ld, 8'h00);
    lrb(8'h00, 16'h0, 9'h100); chk(ld, 8'h10);
    lrb(8'h00, 16'h0, 9'h13E); chk(ld, 8'h10);
    lrb(8'h00, 16'h0, 9'h13F); chk(ld, 8'h00);
    for (int k = 0; k < 2; k++) begin
      axi_wr(8'h00, k ? 32'h1F : 32'h10);
      for (int b = 32; b < 48; b++) begin
        lrb(8'h00, 16'h0, b[8:0]);
        chk(ld, k && (b inside {32, 34, 36, 42}));
      end
    end
    lrb(8'h00, 16'h1, 9'h000); chk(la, 1'h1);
    lrb(8'h05, 16'h0, 9'h000); chk(la, 1'h1);
    lrb(8'h80, 16'h0, 9'h000); chk(la, 1'h1);
    $display("test directory done");
    lchk(9'h000, 8'h01);
    lchk(9'h002, 8'h00);
    lchk(9'h1FF, 8'hFF);
    pulse_ev(2, 8'h04, 1'h1);
    lchk(9'h002, 8'h00);
    lchk(9'h1F4, 8'h00);
    pulse_ev(0, 8'hA1, 1'h0);
    pulse_ev(0, 8'hB2, 1'h0);
    pwr <= 4'h3;
    pulse_ev(1, 8'h25, 1'h0);
    pwr <= 4'h1;
    pulse_ev(2, 8'h41, 1'h0);
    lchk(9'h002, 8'h01);
    lchk(9'h04D, 8'hB2);
    lchk(9'h04E, 8'hA1);
    lchk(9'h058, 8'h25);
    lchk(9'h05F, 8'h41);
    lchk(9'h060, 8'h5A);
    lchk(9'h069, 8'h51);
    lchk(9'h07D, 8'h03);
    lchk(9'h07E, 8'h23);
    lchk(9'h0DB, 8'h00);
    lchk(9'h1F4, 8'h01);
    axi_rd(8'h04); chk(d, 32'h00010001);
    axi_wr(8'h04, 32'hFFFFFFFF);
    axi_rd(8'h04); chk(d, 32'h00010001);
    s = 0;
    for (int b = 0; b < 511; b++) begin
      lrb(8'h03, 16'h0, b[8:0]);
      s += ld;
    end
    lchk(9'h1FF, 8'(-s));
    $display("test first error done");
    for (int i = 2; i < 6; i++) begin
      pulse_ev(2, 8'h40 + 8'(i), 1'h0);
      if (i == 4) lchk(9'h002, 8'h04);
    end
    lchk(9'h002, 8'h01);
    lchk(9'h05F, 8'h45);
    lchk(9'h0DB, 8'h42);
    axi_wr(8'h00, 32'h0F);
    lrb(8'h03, 16'h0, 9'h000); chk(la, 1'h1);
    axi_wr(8'h00, 32'h1F);
    lrb(8'h03, 16'h1, 9'h000); chk(la, 1'h1);
    $display("test circular done");
    @(posedge clk);
    err_v <= 1'h1;
    err_hf <= 1'h0;
    repeat (65540) @(posedge clk);
    err_v <= 1'h0;
    axi_rd(8'h04); chk(d, 32'hFFFF0001);
    $display("test saturation done");
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    axi_rd(8'h04); chk(d, 32'h0);
    lchk(9'h05F, 8'h00);
    $display("test reset done");
    stop_test;
  end

  initial begin
    #1700000;
    n_errors++;
    stop_test;
  end
endmodule : dlel_log_core_bench
